// ===== rtl/dcache_ctrl.sv
`default_nettype none
module dcache_ctrl
  import dcache_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   cmd_valid,
  input  wire cmd_e                   cmd_op,
  output logic                        cmd_ack,
  output logic                        cache_enabled,
  output logic                        status_valid,
  output logic [WORD_W-1:0]           status_word,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire size_e                  req_size,
  input  wire logic [31:0]            req_addr,
  input  wire logic [LINE_DATA_W-1:0] req_wdata,
  input  wire logic                   req_atomic,
  input  wire logic                   req_intr_table,
  input  wire logic                   region_cache_en,
  output logic                        req_ack,
  output logic                        rdata_valid,
  output logic [LINE_DATA_W-1:0]      rdata,
  output logic                        bus_req,
  output logic                        bus_write,
  output logic [31:0]                 bus_addr,
  output logic [2:0]                  bus_nwords,
  output logic [3:0]                  bus_be,
  output logic [LINE_DATA_W-1:0]      bus_wdata,
  input  wire logic                   bus_ack,
  input  wire logic [LINE_DATA_W-1:0] bus_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_BUS,
    ST_UPD,
    ST_DONE
  } state_e;
  state_e                             st_q;
  logic                               en_q;
  logic                               status_valid_q;
  logic [WORD_W-1:0]                  status_word_q;
  logic                               bus_req_q;
  logic                               bus_write_q;
  logic [31:0]                        bus_addr_q;
  logic [2:0]                         bus_nwords_q;
  logic [3:0]                         bus_be_q;
  logic [LINE_DATA_W-1:0]             bus_wdata_q;
  logic [LINE_DATA_W-1:0]             rdata_q;
  logic [3:0]                         fetch_mask_q;
  logic [1:0]                         cur_q;
  logic                               whole_q;
  logic [1:0]                         upd_q;
  logic [WADDR_W-1:0]                 base_w;
  logic [LINE_WORDS-1:0][WADDR_W-1:0] rd_waddr;
  logic [LINE_WORDS-1:0]              rd_line_hit;
  logic [LINE_WORDS-1:0]              rd_word_hit;
  logic [LINE_WORDS-1:0][WORD_W-1:0]  rd_data;
  logic [2:0]                         nw;
  logic [3:0]                         in_mask;
  logic [3:0]                         hit_vec;
  logic                               cacheable;
  logic                               all_hit;
  logic                               none_hit;
  logic                               aligned;
  logic                               wide;
  logic                               upd_lh;
  logic                               upd_wh;
  logic                               upd_last;
  logic [3:0]                         rem_mask;
  wmode_e                             wr_mode;
  logic [3:0]                         wr_be;
  logic [WORD_W-1:0]                  wr_data;
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign base_w = req_addr[31:2];
  assign nw     = size_words(req_size);
  assign wide   = (req_size != SZ_BYTE) && (req_size != SZ_HALF);
  for (genvar p = 0; p < LINE_WORDS; p++) begin : g_word
    assign rd_waddr[p] = base_w + WADDR_W'(p);
    assign in_mask[p]  = (3'(p) < nw);
    assign hit_vec[p]  = rd_word_hit[p] && in_mask[p];
  end
  assign cacheable = en_q && region_cache_en && !req_intr_table &&
                     !(req_atomic && !req_write);
  assign all_hit   = (hit_vec == in_mask);
  assign none_hit  = (hit_vec == 4'h0);
  assign aligned   = nat_aligned(req_size, req_addr[3:0]);
  assign upd_lh    = rd_line_hit[upd_q];
  assign upd_wh    = rd_word_hit[upd_q];
  assign upd_last  = ({1'b0, upd_q} == (nw - 3'h1));
  assign rem_mask  = fetch_mask_q & ~(4'h1 << cur_q);
  cache_store_array #(
    .LINES_P (LINES)
  ) u_store (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .rd_waddr    (rd_waddr),
    .rd_line_hit (rd_line_hit),
    .rd_word_hit (rd_word_hit),
    .rd_data     (rd_data),
    .wr_mode     (wr_mode),
    .wr_waddr    (rd_waddr[upd_q]),
    .wr_be       (wr_be),
    .wr_data     (wr_data)
  );
  // ----------------------------------------------------------------
  // cache update, one word per cycle so words may straddle lines
  // ----------------------------------------------------------------
  always_comb begin
    wr_mode = WM_NONE;
    wr_be   = BE_ALL;
    wr_data = req_write ? req_wdata[WORD_W*upd_q +: WORD_W]
                        : rdata_q[WORD_W*upd_q +: WORD_W];
    if (st_q == ST_UPD) begin
      if (!cacheable) begin
        wr_mode = upd_wh ? WM_INVAL : WM_NONE;
      end else if (!req_write || wide) begin
        wr_mode = upd_lh ? WM_HIT : WM_ALLOC;
      end else begin
        wr_mode = upd_lh ? WM_MERGE : WM_NONE;
        wr_be   = byte_en(req_size, req_addr[1:0]);
        wr_data = req_wdata[WORD_W-1:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  assign cmd_ack = (st_q == ST_IDLE) && cmd_valid;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      en_q <= 1'b0;
    end else if (cmd_ack && cmd_op == CMD_ENABLE) begin
      en_q <= 1'b1;
    end else if (cmd_ack && cmd_op == CMD_DISABLE) begin
      en_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status_valid_q <= 1'b0;
      status_word_q  <= '0;
    end else begin
      status_valid_q <= cmd_ack && cmd_op == CMD_STATUS;
      if (cmd_ack && cmd_op == CMD_STATUS) begin
        status_word_q <= {STAT_LINES, STAT_WORDS, 7'h00, en_q};
      end
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q  <= ST_IDLE;
      upd_q <= 2'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          upd_q <= 2'h0;
          if (!cmd_valid && req_valid) begin
            st_q <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          st_q <= (!req_write && cacheable && all_hit) ? ST_DONE : ST_BUS;
        end
        ST_BUS: begin
          if (bus_ack && (whole_q || rem_mask == 4'h0)) begin
            st_q <= ST_UPD;
          end
        end
        ST_UPD: begin
          upd_q <= upd_q + 2'h1;
          if (upd_last) begin
            st_q <= ST_DONE;
          end
        end
        ST_DONE: st_q <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // external bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_req_q    <= 1'b0;
      bus_write_q  <= 1'b0;
      bus_addr_q   <= '0;
      bus_nwords_q <= 3'h0;
      bus_be_q     <= 4'h0;
      bus_wdata_q  <= '0;
      fetch_mask_q <= 4'h0;
      cur_q        <= 2'h0;
      whole_q      <= 1'b0;
    end else if (st_q == ST_LOOKUP) begin
      bus_write_q <= req_write;
      bus_wdata_q <= req_wdata;
      bus_be_q    <= byte_en(req_size, req_addr[1:0]);
      if (req_write) begin
        bus_req_q    <= 1'b1;
        whole_q      <= 1'b1;
        bus_addr_q   <= {base_w, 2'h0};
        bus_nwords_q <= nw;
      end else if (!(cacheable && all_hit)) begin
        bus_req_q <= 1'b1;
        if (!cacheable || none_hit || aligned) begin
          whole_q      <= 1'b1;
          fetch_mask_q <= in_mask;
          bus_addr_q   <= {base_w, 2'h0};
          bus_nwords_q <= nw;
        end else begin
          whole_q      <= 1'b0;
          fetch_mask_q <= in_mask & ~hit_vec;
          cur_q        <= first_bit(in_mask & ~hit_vec);
          bus_addr_q   <= {base_w + WADDR_W'(first_bit(in_mask & ~hit_vec)),
                           2'h0};
          bus_nwords_q <= 3'h1;
        end
      end
    end else if (st_q == ST_BUS && bus_ack) begin
      fetch_mask_q <= rem_mask;
      if (whole_q || rem_mask == 4'h0) begin
        bus_req_q <= 1'b0;
      end else begin
        cur_q      <= first_bit(rem_mask);
        bus_addr_q <= {base_w + WADDR_W'(first_bit(rem_mask)), 2'h0};
      end
    end
  end
  // ----------------------------------------------------------------
  // load data gathering
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (st_q == ST_LOOKUP) begin
      rdata_q <= rd_data;
    end else if (st_q == ST_BUS && bus_ack && !bus_write_q) begin
      if (whole_q) begin
        rdata_q <= bus_rdata;
      end else begin
        rdata_q[WORD_W*cur_q +: WORD_W] <= bus_rdata[WORD_W-1:0];
      end
    end
  end
  assign req_ack       = (st_q == ST_DONE);
  assign rdata_valid   = (st_q == ST_DONE) && !req_write;
  assign rdata         = rdata_q;
  assign cache_enabled = en_q;
  assign status_valid  = status_valid_q;
  assign status_word   = status_word_q;
  assign bus_req       = bus_req_q;
  assign bus_write     = bus_write_q;
  assign bus_addr      = bus_addr_q;
  assign bus_nwords    = bus_nwords_q;
  assign bus_be        = bus_be_q;
  assign bus_wdata     = bus_wdata_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reset_disabled_a: assert property (disable iff (1'b0)
    !rst_b |=> !cache_enabled && st_q == ST_IDLE)
    else $error("cache not disabled after reset");
  enable_cmd_a: assert property (
    cmd_ack && cmd_op == CMD_ENABLE |=> cache_enabled)
    else $error("enable command ignored");
  disable_cmd_a: assert property (
    cmd_ack && cmd_op == CMD_DISABLE |=> !cache_enabled)
    else $error("disable command ignored");
  status_rpt_a: assert property (
    cmd_ack && cmd_op == CMD_STATUS
    |=> status_valid && status_word[STAT_EN_BIT] == $past(en_q))
    else $error("status report wrong");
  off_fetch_a: assert property (
    st_q == ST_LOOKUP && !en_q && !req_write |=> bus_req && !bus_write)
    else $error("disabled load not sent to bus");
  miss_whole_a: assert property (
    st_q == ST_LOOKUP && !req_write && cacheable && none_hit
    |=> bus_nwords == $past(nw) && bus_addr[1:0] == 2'h0)
    else $error("full miss not one transaction");
  full_hit_a: assert property (
    st_q == ST_LOOKUP && !req_write && cacheable && all_hit
    |=> !bus_req [*2])
    else $error("full hit reached the bus");
  store_out_a: assert property (
    st_q == ST_LOOKUP && req_write
    |=> bus_req && bus_write && bus_nwords == $past(nw))
    else $error("store not written through");
  widen_a: assert property (
    st_q == ST_LOOKUP && !req_write && !wide && !(cacheable && all_hit)
    |=> bus_nwords == 3'h1 && bus_addr[1:0] == 2'h0)
    else $error("sub-word load not widened");
  gap_fetch_a: assert property (
    st_q == ST_LOOKUP && !req_write && cacheable && !none_hit &&
    !all_hit && !aligned |=> bus_nwords == 3'h1 && !whole_q)
    else $error("unaligned partial hit refetched all");
  small_miss_a: assert property (
    st_q == ST_UPD && req_write && !wide && !upd_lh |-> wr_mode == WM_NONE)
    else $error("sub-word miss changed cache");
  nc_inval_a: assert property (
    st_q == ST_UPD && !cacheable && upd_wh |-> wr_mode == WM_INVAL)
    else $error("uncached hit not invalidated");
  load_strobe_a: assert property (
    st_q == ST_LOOKUP && !req_write ##1 st_q == ST_DONE
    |-> rdata_valid && req_ack)
    else $error("load answered without data strobe");
  hit_load_c:   cover property (st_q == ST_LOOKUP && !req_write &&
                                cacheable && all_hit && nw == 3'h4);
  gap_load_c:   cover property (st_q == ST_BUS && !whole_q && bus_ack);
  store_miss_c: cover property (st_q == ST_UPD && wr_mode == WM_ALLOC &&
                                req_write);
  nc_inval_c:   cover property (wr_mode == WM_INVAL);
endmodule
`default_nettype wire

// ===== rtl/dcache_pkg.sv
`default_nettype none
package dcache_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int CACHE_BYTES = 4096;
  localparam int LINE_WORDS  = 4;
  localparam int WORD_W      = 32;
  localparam int WORD_BYTES  = 4;
  localparam int LINES       = CACHE_BYTES / (LINE_WORDS * WORD_BYTES);
  localparam int IDX_W       = 8;
  localparam int WADDR_W     = 30;
  localparam int SEL_W       = 2;
  localparam int TAG_W       = WADDR_W - IDX_W - SEL_W;
  localparam int IDX_LSB     = SEL_W;
  localparam int TAG_LSB     = SEL_W + IDX_W;
  localparam int LINE_DATA_W = LINE_WORDS * WORD_W;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  BE_ALL      = 4'hf;
  localparam logic [3:0]  BE_BYTE     = 4'h1;
  localparam logic [3:0]  BE_HALF     = 4'h3;
  localparam logic [15:0] STAT_LINES  = 16'h0100;
  localparam logic [7:0]  STAT_WORDS  = 8'h04;
  localparam int          STAT_EN_BIT = 0;

  typedef enum logic [2:0] {
    SZ_BYTE   = 3'h0,
    SZ_HALF   = 3'h1,
    SZ_WORD   = 3'h2,
    SZ_DOUBLE = 3'h3,
    SZ_TRIPLE = 3'h4,
    SZ_QUAD   = 3'h5
  } size_e;

  typedef enum logic [1:0] {
    CMD_ENABLE  = 2'h0,
    CMD_DISABLE = 2'h1,
    CMD_STATUS  = 2'h2
  } cmd_e;

  typedef enum logic [2:0] {
    WM_NONE  = 3'h0,
    WM_ALLOC = 3'h1,
    WM_HIT   = 3'h2,
    WM_MERGE = 3'h3,
    WM_INVAL = 3'h4
  } wmode_e;

  // sub-word sizes move one promoted word
  function automatic logic [2:0] size_words(input size_e s);
    unique case (s)
      SZ_DOUBLE: size_words = 3'h2;
      SZ_TRIPLE: size_words = 3'h3;
      SZ_QUAD:   size_words = 3'h4;
      default:   size_words = 3'h1;
    endcase
  endfunction

  function automatic logic nat_aligned(input size_e s, input logic [3:0] a);
    unique case (s)
      SZ_DOUBLE: nat_aligned = (a[2:0] == 3'h0);
      SZ_TRIPLE,
      SZ_QUAD:   nat_aligned = (a == 4'h0);
      default:   nat_aligned = 1'b1;
    endcase
  endfunction

  function automatic logic [3:0] byte_en(input size_e s, input logic [1:0] a);
    unique case (s)
      SZ_BYTE: byte_en = BE_BYTE << a;
      SZ_HALF: byte_en = BE_HALF << {a[1], 1'b0};
      default: byte_en = BE_ALL;
    endcase
  endfunction

  function automatic logic [1:0] first_bit(input logic [3:0] m);
    first_bit = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

endpackage
`default_nettype wire

// ===== rtl/cache_store_array.sv
`default_nettype none
module cache_store_array
  import dcache_pkg::*;
#(
  parameter int LINES_P = LINES
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rst_b,
  input  wire logic [LINE_WORDS-1:0][WADDR_W-1:0] rd_waddr,
  output logic      [LINE_WORDS-1:0]            rd_line_hit,
  output logic      [LINE_WORDS-1:0]            rd_word_hit,
  output logic      [LINE_WORDS-1:0][WORD_W-1:0] rd_data,
  input  wire wmode_e                           wr_mode,
  input  wire logic [WADDR_W-1:0]               wr_waddr,
  input  wire logic [3:0]                       wr_be,
  input  wire logic [WORD_W-1:0]                wr_data
);

  if (LINES_P != (1 << IDX_W)) begin : g_chk
    $error("cache_store_array: line count must match index width");
  end

  logic [TAG_W-1:0]             tag_mem  [LINES_P];
  logic [WORD_W-1:0]            data_mem [LINES_P*LINE_WORDS];
  logic [LINES_P-1:0]           line_v_q;
  logic [LINES_P*LINE_WORDS-1:0] word_v_q;

  function automatic logic [IDX_W-1:0] idx_of(input logic [WADDR_W-1:0] w);
    idx_of = w[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic [IDX_W+SEL_W-1:0] slot_of(
    input logic [WADDR_W-1:0] w);
    slot_of = w[0 +: IDX_W+SEL_W];
  endfunction

  // ----------------------------------------------------------------
  // lookup ports
  // ----------------------------------------------------------------
  for (genvar p = 0; p < LINE_WORDS; p++) begin : g_rd
    assign rd_line_hit[p] = line_v_q[idx_of(rd_waddr[p])] &&
      (tag_mem[idx_of(rd_waddr[p])] == rd_waddr[p][TAG_LSB +: TAG_W]);
    assign rd_word_hit[p] = rd_line_hit[p] &&
      word_v_q[slot_of(rd_waddr[p])];
    assign rd_data[p] = data_mem[slot_of(rd_waddr[p])];
  end

  // ----------------------------------------------------------------
  // valid bits
  // ----------------------------------------------------------------
  // valids cleared
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      line_v_q <= '0;
      word_v_q <= '0;
    end else begin
      unique case (wr_mode)
        WM_ALLOC: begin
          line_v_q[idx_of(wr_waddr)] <= 1'b1;
          for (int w = 0; w < LINE_WORDS; w++) begin
            word_v_q[{idx_of(wr_waddr), SEL_W'(w)}] <=
              (SEL_W'(w) == wr_waddr[SEL_W-1:0]);
          end
        end
        WM_HIT:   word_v_q[slot_of(wr_waddr)] <= 1'b1;
        WM_INVAL: word_v_q[slot_of(wr_waddr)] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // tag and data storage, no reset: valid bits guard them
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr_mode == WM_ALLOC) begin
      tag_mem[idx_of(wr_waddr)] <= wr_waddr[TAG_LSB +: TAG_W];
    end
    if (wr_mode inside {WM_ALLOC, WM_HIT, WM_MERGE}) begin
      for (int b = 0; b < WORD_BYTES; b++) begin
        if (wr_be[b]) begin
          data_mem[slot_of(wr_waddr)][8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verif/ext_mem_model.sv
`default_nettype none
module ext_mem_model
  import dcache_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   bus_req,
  input  wire logic                   bus_write,
  input  wire logic [31:0]            bus_addr,
  input  wire logic [2:0]             bus_nwords,
  input  wire logic [3:0]             bus_be,
  input  wire logic [LINE_DATA_W-1:0] bus_wdata,
  input  wire logic [1:0]             lat,
  output logic                        bus_ack,
  output logic [LINE_DATA_W-1:0]      bus_rdata,
  output logic [15:0]                 n_txn,
  output logic [2:0]                  last_nw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] mem [256];
  logic [1:0]        wait_q;
  logic [7:0]        wi;
  assign wi = bus_addr[9:2];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h5a00_0000 + i * 32'h0001_0101;
  end
  always @(posedge clk_sys) begin
    bus_ack <= 1'b0;
    // released bus inverts the last data every cycle
    bus_rdata <= ~bus_rdata;
    if (!rst_b) begin
      n_txn <= 16'h0000;
      wait_q <= 2'h0;
      last_nw <= 3'h0;
      bus_rdata <= {4{32'hc3c3_0f0f}};
    end else if (bus_req && !bus_ack) begin
      if (wait_q != lat) wait_q <= wait_q + 2'h1;
      else begin
        wait_q <= 2'h0;
        bus_ack <= 1'b1;
        n_txn <= n_txn + 16'h0001;
        last_nw <= bus_nwords;
        for (int i = 0; i < 4; i++) if (i < bus_nwords) begin
          bus_rdata[32*i+:32] <= mem[wi+8'(i)];
          if (bus_write) for (int b = 0; b < 4; b++)
            if (i > 0 || bus_be[b])
              mem[wi+8'(i)][8*b+:8] <= bus_wdata[32*i+8*b+:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/dcache_ctrl_bench.sv
`default_nettype none
module dcache_ctrl_bench
  import dcache_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys, rst_b, cmd_valid, cmd_ack, cache_enabled;
  logic         status_valid, req_valid, req_write, req_atomic, req_ack;
  logic         req_intr_table, region_cache_en, rdata_valid;
  logic         bus_req, bus_write, bus_ack;
  cmd_e         cmd_op;
  size_e        req_size;
  logic [31:0]  status_word, req_addr, bus_addr, shadow [256];
  logic [127:0] req_wdata, rdata, bus_wdata, bus_rdata;
  logic [2:0]   bus_nwords, last_nw;
  logic [3:0]   bus_be;
  logic [1:0]   lat;
  logic [15:0]  n_txn;
  logic [255:0] expq [$];
  logic [255:0] ent;
  int           num_errors, n_checks, cycles, seed;
  dcache_ctrl dut (.clk_sys, .rst_b, .cmd_valid, .cmd_op, .cmd_ack,
    .cache_enabled, .status_valid, .status_word, .req_valid, .req_write,
    .req_size, .req_addr, .req_wdata, .req_atomic, .req_intr_table,
    .region_cache_en, .req_ack, .rdata_valid, .rdata, .bus_req, .bus_write,
    .bus_addr, .bus_nwords, .bus_be, .bus_wdata, .bus_ack, .bus_rdata);
  ext_mem_model mdl (.clk_sys, .rst_b, .bus_req, .bus_write, .bus_addr,
    .bus_nwords, .bus_be, .bus_wdata, .lat, .bus_ack, .bus_rdata, .n_txn,
    .last_nw);
  always #25 clk_sys = ~clk_sys;
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmd(input cmd_e op);
    @(posedge clk_sys);
    #2;
    cmd_valid = 1'b1;
    cmd_op = op;
    @(negedge clk_sys);
    while (cmd_ack !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    #2;
    cmd_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic acc(input logic w, input size_e sz, input logic [31:0] a,
    input int nw, input logic rg, input logic [1:0] at, input int dtx,
    input int lnw);
    logic [127:0] wd, ex, mk;
    logic [15:0]  t0;
    logic [7:0]   wi;
    wd = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {wi, t0, ex, mk} = {a[9:2], n_txn, 256'h0};
    @(posedge clk_sys);
    #2;
    lat = 2'($random(seed));
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, wd};
    req_size = sz;
    {region_cache_en, req_intr_table, req_atomic} = {rg, at};
    for (int i = 0; i < nw; i++) begin
      if (w && sz == SZ_BYTE) shadow[wi][8*a[1:0]+:8] = wd[8*a[1:0]+:8];
      else if (w) shadow[wi+8'(i)] = wd[32*i+:32];
      ex[32*i+:32] = shadow[wi+8'(i)];
      mk[32*i+:32] = '1;
    end
    if (!w) expq.push_back({mk, ex});
    @(negedge clk_sys);
    while (req_ack !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    #2;
    req_valid = 1'b0;
    if (dtx >= 0) check(n_txn - t0, dtx);
    if (lnw > 0) check(last_nw, lnw);
  endtask
  always @(negedge clk_sys) begin
    if (rdata_valid === 1'b1) begin
      if (expq.size() == 0) check(rdata_valid, 1'b0);
      else begin
        ent = expq.pop_front();
        check(rdata & ent[255:128], ent[127:0]);
      end
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {clk_sys, rst_b, cmd_valid, req_valid, req_write, req_atomic} = '0;
    {req_intr_table, region_cache_en, req_addr, req_wdata, lat} = '0;
    cmd_op = CMD_STATUS;
    req_size = SZ_WORD;
    seed = 32'hc44b;
    for (int i = 0; i < 256; i++) shadow[i] = 32'h5a00_0000 + i * 32'h0001_0101;
    repeat (20) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    cmd(CMD_STATUS);
    check(status_word, {STAT_LINES, STAT_WORDS, 8'h00});
    check(status_valid, 1'b1);
    acc(0, SZ_QUAD, 32'h40, 4, 1, 0, 1, 4);
    acc(0, SZ_QUAD, 32'h40, 4, 1, 0, 1, 4);
    acc(0, SZ_BYTE, 32'h51, 1, 1, 0, 1, 1);
    cmd(CMD_ENABLE);
    cmd(CMD_STATUS);
    check(status_word, {STAT_LINES, STAT_WORDS, 8'h01});
    acc(0, SZ_QUAD, 32'h80, 4, 0, 0, 1, 4);
    acc(0, SZ_WORD, 32'h80, 1, 1, 2, 1, 1);
    acc(0, SZ_QUAD, 32'h80, 4, 1, 0, 1, 4);
    acc(0, SZ_QUAD, 32'h80, 4, 1, 0, 0, 0);
    acc(1, SZ_WORD, 32'h84, 1, 1, 0, 1, 1);
    acc(1, SZ_BYTE, 32'h85, 1, 1, 0, 1, 1);
    acc(1, SZ_DOUBLE, 32'h88, 2, 1, 0, 1, 2);
    acc(0, SZ_QUAD, 32'h80, 4, 1, 0, 0, 0);
    acc(0, SZ_DOUBLE, 32'h8C, 2, 1, 0, 1, 1);
    acc(0, SZ_DOUBLE, 32'h8C, 2, 1, 0, 0, 0);
    acc(0, SZ_DOUBLE, 32'h90, 2, 1, 0, 1, 2);
    acc(1, SZ_BYTE, 32'h9A, 1, 1, 0, 1, 1);
    acc(0, SZ_WORD, 32'h98, 1, 1, 0, 1, 1);
    acc(1, SZ_BYTE, 32'h1C1, 1, 1, 0, 1, 1);
    acc(0, SZ_WORD, 32'h1C0, 1, 1, 0, 1, 1);
    acc(0, SZ_QUAD, 32'h100, 4, 1, 0, 1, 4);
    acc(1, SZ_WORD, 32'h1100, 1, 1, 0, 1, 1);
    acc(0, SZ_WORD, 32'h1100, 1, 1, 0, 0, 0);
    acc(0, SZ_WORD, 32'h1104, 1, 1, 0, 1, 1);
    acc(0, SZ_WORD, 32'h84, 1, 1, 1, 1, 1);
    acc(0, SZ_WORD, 32'h84, 1, 1, 0, 1, 1);
    acc(1, SZ_WORD, 32'h88, 1, 0, 0, 1, 1);
    acc(0, SZ_WORD, 32'h88, 1, 1, 0, 1, 1);
    cmd(CMD_DISABLE);
    check(cache_enabled, 1'b0);
    acc(1, SZ_WORD, 32'h80, 1, 1, 0, 1, 1);
    cmd(CMD_ENABLE);
    acc(0, SZ_WORD, 32'h80, 1, 1, 0, 1, 1);
    for (int k = 0; k < 12; k++)
      acc(1'($random(seed)), SZ_WORD, {22'h0, 8'($random(seed)), 2'h0}, 1,
          1'($random(seed)), 0, -1, 1);
    final_report();
  end
endmodule
`default_nettype wire
